// [dv/irpc_codec_tb_top.sv]
`timescale 1ns/10ps
module irpc_codec_tb_top;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clk_sys_in, reset_n_in, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic baud_tick, core_tx, core_rx, rx_pin, tx_pin, bclk, err, inv_rx;
   logic tx_wr, rx_wr;
   logic [15:0] baud_q, txd_q, rx_data, mode_q;
   int n_fail, checks_done;
   int tick_cnt = 0;

   irpc_codec i_irpc_codec (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .baud_tick_in(baud_tick),
      .core_tx_bit_in(core_tx), .core_rx_bit_out(core_rx),
      .serial_receive_pin_in(rx_pin), .serial_transmit_pin_out(tx_pin),
      .baud_clock_out_pin_out(bclk), .mode_out(mode_q),
      .baud_divisor_out(baud_q), .tx_data_out(txd_q),
      .tx_data_wr_out(tx_wr), .rx_data_in(rx_data),
      .rx_data_wr_in(rx_wr));

   irpc_ir_xcvr i_irpc_ir_xcvr (.clk_sys_in(clk_sys_in), .ir_tx_in(tx_pin),
      .invert_in(inv_rx), .ir_rx_out(rx_pin));

   // ----------------------------------------------------------------
   // clock and 16x baud ticks (one pulse every 8 cycles)
   // ----------------------------------------------------------------
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   initial begin
      baud_tick = 1'b0;
      forever begin
         repeat (7) @(posedge clk_sys_in);
         baud_tick <= 1'b1;
         @(posedge clk_sys_in);
         baud_tick <= 1'b0;
      end
   end

   // ticks counted at the edge the design takes them, race free
   always @(posedge clk_sys_in) begin
      if (baud_tick) begin
         tick_cnt <= tick_cnt + 1;
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one apb transfer; the leading edge keeps strobes from colliding
   task automatic apb(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wdat);
      @(posedge clk_sys_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdat;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      @(posedge clk_sys_in);
      while (pready !== 1'b1) @(posedge clk_sys_in);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_tk(input int n);
      while (tick_cnt < n) @(posedge clk_sys_in);
      repeat (2) @(posedge clk_sys_in);
   endtask : wait_tk

   task automatic watch_bclk(input int n, output logic hi);
      hi = 1'b0;
      repeat (n) begin
         @(posedge clk_sys_in);
         hi = hi | bclk;
      end
   endtask : watch_bclk

   task automatic conclude;
      $display("fails %0d checks %0d", n_fail, checks_done);
      if (n_fail == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      apb(1'b0, irpc_pkg::MODE_OFS, 32'h0);
      check("mode rst", rd, {16'h0, irpc_pkg::MODE_RST});
      apb(1'b0, irpc_pkg::STAT_OFS, 32'h0);
      check("stat rst", rd, {16'h0, irpc_pkg::STAT_RST});
      apb(1'b0, 12'h018, 32'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      apb(1'b1, irpc_pkg::BRG_OFS, 32'h0000_1234);
      apb(1'b0, irpc_pkg::BRG_OFS, 32'h0);
      check("baud rd", rd, 32'h0000_1234);
      check("baud out", {16'h0, baud_q}, 32'h0000_1234);
      apb(1'b1, irpc_pkg::TXD_OFS, 32'h0000_00a5);
      // the write strobe stands one cycle; look at it mid-cycle
      @(negedge clk_sys_in);
      check("tx wr", {31'h0, tx_wr}, 32'h1);
      check("tx data", {16'h0, txd_q}, 32'h0000_00a5);
      @(posedge clk_sys_in);
      rx_data <= 16'h01c3;
      rx_wr <= 1'b1;
      @(posedge clk_sys_in);
      rx_wr <= 1'b0;
      apb(1'b0, irpc_pkg::RXD_OFS, 32'h0);
      check("rx data", rd, 32'h0000_01c3);
   endtask : t_regs

   // baud clock pin: only with pin select 11, silent in sleep
   task automatic t_bclk;
      logic hi;
      apb(1'b1, irpc_pkg::MODE_OFS, 32'h0000_8300);
      watch_bclk(24, hi);
      check("bclk on", {31'h0, hi}, 32'h1);
      check("mode out", {16'h0, mode_q}, 32'h0000_8300);
      apb(1'b1, irpc_pkg::CTRL_OFS, 32'h0000_0001);
      repeat (3) @(posedge clk_sys_in);
      watch_bclk(40, hi);
      check("bclk sleep", {31'h0, hi}, 32'h0);
      apb(1'b0, irpc_pkg::CTRL_OFS, 32'h0);
      check("ctrl rd", rd, 32'h0000_0003);
      apb(1'b1, irpc_pkg::CTRL_OFS, 32'h0);
      apb(1'b1, irpc_pkg::MODE_OFS, 32'h0000_8200);
      repeat (3) @(posedge clk_sys_in);
      watch_bclk(40, hi);
      check("bclk other", {31'h0, hi}, 32'h0);
   endtask : t_bclk

   // codec off: plain pass-through, polarity bit has no say
   task automatic t_plain;
      inv_rx <= 1'b0;
      apb(1'b1, irpc_pkg::STAT_OFS, 32'h0000_4110);
      apb(1'b1, irpc_pkg::MODE_OFS, 32'h0000_8000);
      for (int b = 0; b < 2; b++) begin
         core_tx <= b[0];
         repeat (10) @(posedge clk_sys_in);
         check("plain tx", {31'h0, tx_pin}, {31'h0, b[0]});
         check("plain rx", {31'h0, core_rx}, {31'h0, b[0]});
      end
   endtask : t_plain

   // encoder: idle level, ones stay dark, zero gives a 3 tick pulse
   task automatic t_enc(input logic inv);
      logic moved;
      int t1;
      apb(1'b1, irpc_pkg::MODE_OFS, 32'h0000_8000);
      apb(1'b1, irpc_pkg::STAT_OFS, {17'h0, inv, 14'h0110});
      core_tx <= 1'b1;
      apb(1'b1, irpc_pkg::MODE_OFS, 32'h0000_9000);
      moved = 1'b0;
      repeat (140) begin
         @(posedge clk_sys_in);
         moved = moved | (tx_pin !== inv);
      end
      check("tx idle", {31'h0, tx_pin}, {31'h0, inv});
      check("one dark", {31'h0, moved}, 32'h0);
      core_tx <= 1'b0;
      while (tx_pin === inv) @(posedge clk_sys_in);
      t1 = tick_cnt;
      while (tx_pin !== inv) @(posedge clk_sys_in);
      check("pulse len", tick_cnt - t1, 32'd3);
      while (tx_pin === inv) @(posedge clk_sys_in);
      check("bit period", tick_cnt - t1, 32'd16);
      core_tx <= 1'b1;
   endtask : t_enc

   // decoder over the loop: lag from bit start, 16 ticks per fall
   task automatic t_dec(input logic inv, input int n);
      int t0;
      int c;
      int lag;
      lag = inv ? 7 : 10;
      inv_rx <= inv;
      apb(1'b1, irpc_pkg::MODE_OFS, 32'h0000_8000);
      apb(1'b1, irpc_pkg::STAT_OFS, 32'h0000_0110);
      core_tx <= 1'b1;
      apb(1'b1, irpc_pkg::MODE_OFS, 32'h0000_9000);
      // handing the pin to the codec may leave one stray fall; the
      // first bit stays dark so that window lapses before timing
      @(posedge clk_sys_in);
      t0 = tick_cnt + 16;
      wait_tk(t0 + 2);
      check("dec idle", {31'h0, core_rx}, 32'h1);
      core_tx <= 1'b0;
      while (core_rx !== 1'b0) @(posedge clk_sys_in);
      c = tick_cnt;
      check("lag", 32'(c - t0 - 1 == lag || c - t0 - 1 == lag + 1), 1);
      wait_tk(t0 + 12 + 16 * (n - 1));
      core_tx <= 1'b1;
      wait_tk(c + 16 * n - 1);
      check("dec low", {31'h0, core_rx}, 32'h0);
      wait_tk(c + 16 * n + 1);
      check("dec high", {31'h0, core_rx}, 32'h1);
   endtask : t_dec

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      reset_n_in = 1'b0;
      {psel, penable, pwrite, core_tx, rx_wr, inv_rx} = 6'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      rx_data = 16'h0000;
      n_fail = 0;
      checks_done = 0;
      repeat (5) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      t_regs();
      t_bclk();
      t_plain();
      t_enc(1'b0);
      t_enc(1'b1);
      t_dec(1'b1, 1);
      t_dec(1'b0, 1);
      t_dec(1'b1, 2);
      conclude();
   end

   // whole run needs a few thousand cycles; this leaves ample slack
   initial begin
      #(400_000);
      n_fail++;
      conclude();
   end
endmodule : irpc_codec_tb_top

// [dv/irpc_ir_xcvr.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// infrared transceiver: loops the emitted light back to the receiver
// ----------------------------------------------------------------
module irpc_ir_xcvr (
   input wire logic clk_sys_in,
   input wire logic ir_tx_in,
   input wire logic invert_in,
   output logic ir_rx_out
);
   // one cycle of flight; a low-active photo receiver inverts the light
   always_ff @(posedge clk_sys_in) begin
      ir_rx_out <= invert_in ? ~ir_tx_in : ir_tx_in;
   end
endmodule : irpc_ir_xcvr

// [rtl/irpc_codec.sv]
`timescale 1ns/10ps
module irpc_codec (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic baud_tick_in,
   input wire logic core_tx_bit_in,
   output logic core_rx_bit_out,
   input wire logic serial_receive_pin_in,
   output logic serial_transmit_pin_out,
   output logic baud_clock_out_pin_out,
   output logic [15:0] mode_out,
   output logic [15:0] baud_divisor_out,
   output logic [15:0] tx_data_out,
   output logic tx_data_wr_out,
   input wire logic [15:0] rx_data_in,
   input wire logic rx_data_wr_in
);
   irpc_pkg::irpc_regs_t regs_reg;
   irpc_pkg::irpc_regs_t regs_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic txwr_reg;
   logic txwr_next;
   logic bclk_reg;
   logic bclk_next;
   logic [2:0] bdiv_reg;
   logic [2:0] bdiv_next;
   logic rx_s1_reg;
   logic rx_s2_reg;
   logic rx_s3_reg;
   logic rx_sync_reg;
   logic port_en;
   logic ir_en;
   logic tx_inv;
   logic enc_run;
   logic enc_tx;
   logic dec_rx;
   logic access;
   logic wr;
   logic mapped;

   // ----------------------------------------------------------------
   // apb slave, zero wait states
   // ----------------------------------------------------------------
   assign access = psel_in && penable_in;
   assign wr = access && pwrite_in;
   assign mapped = paddr_in == irpc_pkg::MODE_OFS ||
      paddr_in == irpc_pkg::STAT_OFS || paddr_in == irpc_pkg::TXD_OFS ||
      paddr_in == irpc_pkg::RXD_OFS || paddr_in == irpc_pkg::BRG_OFS ||
      paddr_in == irpc_pkg::CTRL_OFS;
   assign pready_out = 1'b1;
   // unmapped addresses answer with an error, writes dropped
   assign pslverr_out = access && !mapped;
   assign prdata_out = rdata_reg;

   // register writes and read data
   always_comb begin
      regs_next = regs_reg;
      rdata_next = rdata_reg;
      txwr_next = 1'b0;
      if (rx_data_wr_in) begin
         regs_next.rxd = rx_data_in;
      end
      if (wr) begin
         case (paddr_in)
            irpc_pkg::MODE_OFS: regs_next.mode = pwdata_in[15:0];
            irpc_pkg::STAT_OFS: regs_next.stat = pwdata_in[15:0];
            irpc_pkg::BRG_OFS: regs_next.brg = pwdata_in[15:0];
            irpc_pkg::TXD_OFS: begin
               regs_next.txd = pwdata_in[15:0];
               txwr_next = 1'b1;
            end
            irpc_pkg::CTRL_OFS: begin
               regs_next.sleep = pwdata_in[irpc_pkg::SLEEP_BIT];
            end
            default: begin
               regs_next.sleep = regs_reg.sleep;
            end
         endcase
      end
      if (psel_in && !penable_in && !pwrite_in) begin
         case (paddr_in)
            irpc_pkg::MODE_OFS: rdata_next = {16'h0000, regs_reg.mode};
            irpc_pkg::STAT_OFS: rdata_next = {16'h0000, regs_reg.stat};
            irpc_pkg::BRG_OFS: rdata_next = {16'h0000, regs_reg.brg};
            irpc_pkg::RXD_OFS: rdata_next = {16'h0000, regs_reg.rxd};
            irpc_pkg::CTRL_OFS: begin
               rdata_next = {30'h00000000, dec_rx, regs_reg.sleep};
            end
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         regs_reg <= '{mode: irpc_pkg::MODE_RST, stat: irpc_pkg::STAT_RST,
            brg: irpc_pkg::BRG_RST, txd: 16'h0000,
            rxd: irpc_pkg::RXD_RST, sleep: 1'b0};
         rdata_reg <= 32'h00000000;
         txwr_reg <= 1'b0;
      end else begin
         regs_reg <= regs_next;
         rdata_reg <= rdata_next;
         txwr_reg <= txwr_next;
      end
   end

   // ----------------------------------------------------------------
   // control decode
   // ----------------------------------------------------------------
   assign port_en = regs_reg.mode[irpc_pkg::PORT_EN_BIT];
   assign ir_en = regs_reg.mode[irpc_pkg::IR_EN_BIT];
   assign tx_inv = regs_reg.stat[irpc_pkg::TX_INV_BIT];
   assign enc_run = port_en && ir_en && !regs_reg.sleep;
   assign mode_out = regs_reg.mode;
   assign baud_divisor_out = regs_reg.brg;
   assign tx_data_out = regs_reg.txd;
   assign tx_data_wr_out = txwr_reg;

   // ----------------------------------------------------------------
   // 16x baud clock out: each tick gives a one-cycle high pulse
   // ----------------------------------------------------------------
   // registered high for one cycle after the tick, so the pin stays glitch free
   always_comb begin
      bdiv_next = bdiv_reg;
      bclk_next = bclk_reg;
      if (!port_en || regs_reg.sleep ||
          regs_reg.mode[irpc_pkg::PIN_SEL_LO +: 2] !=
          irpc_pkg::PIN_SEL_BCLK) begin
         bclk_next = 1'b0;
         bdiv_next = 3'h0;
      end else if (baud_tick_in) begin
         bclk_next = 1'b1;
         bdiv_next = 3'h0;
      end else if (bclk_reg) begin
         bdiv_next = bdiv_reg + 3'h1;
         if (bdiv_reg == 3'h0) begin
            bclk_next = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         bclk_reg <= 1'b0;
         bdiv_reg <= 3'h0;
      end else begin
         bclk_reg <= bclk_next;
         bdiv_reg <= bdiv_next;
      end
   end

   assign baud_clock_out_pin_out = bclk_reg;

   // ----------------------------------------------------------------
   // pin synchroniser for the plain receive path
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
         rx_s3_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
      end else begin
         rx_s1_reg <= serial_receive_pin_in;
         rx_s2_reg <= rx_s1_reg;
         rx_s3_reg <= rx_s2_reg;
         if (rx_s2_reg == rx_s3_reg) begin
            rx_sync_reg <= rx_s3_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // codec
   // ----------------------------------------------------------------
   irpc_encoder u_enc (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .run_in(enc_run),
      .tick_in(baud_tick_in),
      .tx_bit_in(core_tx_bit_in),
      .ir_tx_out(enc_tx)
   );

   irpc_decoder u_dec (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .run_in(enc_run),
      .tick_in(baud_tick_in),
      .rx_pin_in(serial_receive_pin_in),
      .rx_bit_out(dec_rx)
   );

   // pin routing; polarity only touches the infrared transmit path
   always_comb begin
      if (ir_en) begin
         serial_transmit_pin_out = enc_tx ^ tx_inv;
         core_rx_bit_out = dec_rx;
      end else begin
         serial_transmit_pin_out = core_tx_bit_in;
         core_rx_bit_out = rx_sync_reg;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_bclk_gated: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (regs_reg.sleep || !port_en) |=> !baud_clock_out_pin_out)
      else $error("baud clock pin active while stopped");
   a_bclk_tick: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (baud_tick_in && port_en && !regs_reg.sleep &&
       regs_reg.mode[irpc_pkg::PIN_SEL_LO +: 2] == irpc_pkg::PIN_SEL_BCLK)
      |=> baud_clock_out_pin_out)
      else $error("baud clock pin missed a tick");
   a_idle_level: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (ir_en && !enc_tx) |-> serial_transmit_pin_out == tx_inv)
      else $error("idle transmit level wrong");
   a_plain_tx: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      !ir_en |-> serial_transmit_pin_out == core_tx_bit_in)
      else $error("polarity leaked into plain mode");
   c_ir_mode: cover property (@(posedge clk_sys_in)
      disable iff (!reset_n_in) enc_run && tx_inv);
   c_bclk: cover property (@(posedge clk_sys_in)
      disable iff (!reset_n_in) $rose(baud_clock_out_pin_out));
endmodule : irpc_codec

// [rtl/irpc_decoder.sv]
`timescale 1ns/10ps
module irpc_decoder (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic run_in,
   input wire logic tick_in,
   input wire logic rx_pin_in,
   output logic rx_bit_out
);
   irpc_pkg::irpc_dec_t state_reg;
   irpc_pkg::irpc_dec_t state_next;
   logic rx_s1_reg;
   logic fall;

   // first stage only feeds the second
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         rx_s1_reg <= 1'b1;
      end else begin
         rx_s1_reg <= rx_pin_in;
      end
   end

   // edge counts once stages two and three agree on a change
   assign fall = state_reg.rx_lvl && !state_reg.rx_q2 &&
      !state_reg.rx_q3;

   // --------------------------------------------------------------
   // each fall starts or extends a 16 tick low window; a missed
   // edge gives a one tick high glitch that majority sampling hides
   // --------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.rx_q2 = rx_s1_reg;
      state_next.rx_q3 = state_reg.rx_q2;
      // accepted level moves only when both late stages agree
      if (state_reg.rx_q2 == state_reg.rx_q3) begin
         state_next.rx_lvl = state_reg.rx_q3;
      end
      if (!run_in) begin
         state_next.state = irpc_pkg::DEC_IDLE;
         state_next.cnt = 4'h0;
         state_next.pend = 1'b0;
         state_next.data = 1'b1;
      end else begin
         case (state_reg.state)
            irpc_pkg::DEC_IDLE: begin
               if (fall) begin
                  state_next.state = irpc_pkg::DEC_LOW;
                  state_next.cnt = 4'h0;
                  state_next.pend = 1'b0;
                  state_next.data = 1'b0;
               end
            end
            irpc_pkg::DEC_LOW: begin
               if (fall) begin
                  state_next.pend = 1'b1;
               end
               if (tick_in) begin
                  state_next.cnt = state_reg.cnt + 4'h1;
                  if (state_reg.cnt == irpc_pkg::BIT_PERIODS_M1) begin
                     if (state_reg.pend || fall) begin
                        state_next.pend = 1'b0;
                     end else begin
                        state_next.state = irpc_pkg::DEC_IDLE;
                        state_next.data = 1'b1;
                     end
                  end
               end
            end
            default: begin
               state_next.state = irpc_pkg::DEC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         state_reg <= '{state: irpc_pkg::DEC_IDLE, cnt: 4'h0,
            pend: 1'b0, rx_q2: 1'b1, rx_q3: 1'b1, rx_lvl: 1'b1,
            data: 1'b1};
      end else begin
         state_reg <= state_next;
      end
   end

   assign rx_bit_out = state_reg.data;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   a_fall_low: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (run_in && fall) |=> !rx_bit_out)
      else $error("fall did not drive data low");
   a_low_hold: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (run_in && state_reg.state == irpc_pkg::DEC_LOW &&
       state_reg.cnt != irpc_pkg::BIT_PERIODS_M1) |=> !rx_bit_out)
      else $error("data rose before 16 ticks");
   a_extend_low: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (run_in && state_reg.pend && tick_in &&
       state_reg.cnt == irpc_pkg::BIT_PERIODS_M1) |=> !rx_bit_out)
      else $error("pending fall not extended");
   a_stop_high: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      !run_in |=> rx_bit_out)
      else $error("decoder active while stopped");
   c_extended: cover property (@(posedge clk_sys_in)
      disable iff (!reset_n_in) state_reg.pend);
   c_released: cover property (@(posedge clk_sys_in)
      disable iff (!reset_n_in) $rose(rx_bit_out));
endmodule : irpc_decoder

// [rtl/irpc_encoder.sv]
`timescale 1ns/10ps
module irpc_encoder (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic run_in,
   input wire logic tick_in,
   input wire logic tx_bit_in,
   output logic ir_tx_out
);
   irpc_pkg::irpc_enc_t state_reg;
   irpc_pkg::irpc_enc_t state_next;

   // --------------------------------------------------------------
   // one bit is 16 ticks; a zero bit carries a pulse in ticks 7..9
   // --------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      if (!run_in) begin
         state_next = '0;
      end else if (tick_in) begin
         state_next.phase = state_reg.phase + 4'h1;
         state_next.tx_out = !tx_bit_in &&
            (state_reg.phase >= irpc_pkg::PULSE_START) &&
            (state_reg.phase < irpc_pkg::PULSE_END);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign ir_tx_out = state_reg.tx_out;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   a_one_bit_low: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (run_in && tick_in && tx_bit_in) |=> !ir_tx_out)
      else $error("one bit produced a pulse");
   a_zero_pulse: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (run_in && tick_in && !tx_bit_in && state_reg.phase == 4'h8)
      |=> ir_tx_out)
      else $error("zero bit pulse missing");
   a_zero_edges: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (run_in && tick_in && state_reg.phase == 4'h6) |=> !ir_tx_out)
      else $error("pulse started early");
   c_zero_pulse: cover property (@(posedge clk_sys_in)
      disable iff (!reset_n_in) $rose(ir_tx_out));
endmodule : irpc_encoder

// [rtl/irpc_pkg.sv]
package irpc_pkg;

   // ----------------------------------------------------------------
   // register map (word aligned, apb byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] MODE_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [11:0] TXD_OFS = 12'h008;
   localparam logic [11:0] RXD_OFS = 12'h00c;
   localparam logic [11:0] BRG_OFS = 12'h010;
   localparam logic [11:0] CTRL_OFS = 12'h014;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int PORT_EN_BIT = 15;
   localparam int IR_EN_BIT = 12;
   localparam int PIN_SEL_LO = 8;
   localparam int TX_INV_BIT = 14;
   localparam int SLEEP_BIT = 0;
   localparam logic [1:0] PIN_SEL_BCLK = 2'h3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] STAT_RST = 16'h0110;
   localparam logic [15:0] BRG_RST = 16'h0000;
   localparam logic [15:0] RXD_RST = 16'h0000;

   // ----------------------------------------------------------------
   // timing in 16x baud periods
   // ----------------------------------------------------------------
   localparam logic [3:0] BIT_PERIODS_M1 = 4'hf;
   localparam logic [3:0] PULSE_START = 4'h7;
   localparam logic [3:0] PULSE_END = 4'ha;

   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] stat;
      logic [15:0] brg;
      logic [15:0] txd;
      logic [15:0] rxd;
      logic sleep;
   } irpc_regs_t;

   typedef struct packed {
      logic [3:0] phase;
      logic tx_out;
   } irpc_enc_t;

   typedef enum logic [0:0] {
      DEC_IDLE = 1'b0,
      DEC_LOW = 1'b1
   } irpc_dec_state_t;

   typedef struct packed {
      irpc_dec_state_t state;
      logic [3:0] cnt;
      logic pend;
      logic rx_q2;
      logic rx_q3;
      logic rx_lvl;
      logic data;
   } irpc_dec_t;

endpackage : irpc_pkg
